// File: hw/dhrp_pkg.sv
// Constants and carrier types for the disk host register port.
// Assumes a single 25 MHz core clock and a synchronous active-high reset.
package dhrp_pkg;

  // ==========================================================
  // Command block register addresses
  localparam logic [2:0] CMD_DATA = 3'h0;
  localparam logic [2:0] CMD_ERR_FEAT = 3'h1;
  localparam logic [2:0] CMD_SECT_CNT = 3'h2;
  localparam logic [2:0] CMD_SECT_NUM = 3'h3;
  localparam logic [2:0] CMD_CYL_LOW = 3'h4;
  localparam logic [2:0] CMD_CYL_HIGH = 3'h5;
  localparam logic [2:0] CMD_DEV_HEAD = 3'h6;
  localparam logic [2:0] CMD_STAT_CMD = 3'h7;

  // ==========================================================
  // Control block register addresses
  localparam logic [2:0] CTL_ALT_STAT = 3'h6;
  localparam logic [2:0] CTL_HEAD_READ = 3'h7;

  // ==========================================================
  // Values after reset
  localparam logic [7:0] RST_ERR = 8'h01;
  localparam logic [7:0] RST_SECT_CNT = 8'h01;
  localparam logic [7:0] RST_SECT_NUM = 8'h01;
  localparam logic [7:0] RST_CYL_LOW = 8'h00;
  localparam logic [7:0] RST_CYL_HIGH = 8'h00;
  localparam logic [7:0] RST_DEV_HEAD = 8'h00;

  // ==========================================================
  // Field positions
  localparam int DCTL_SOFT_RESET_POS = 2;
  localparam int DCTL_INT_DISABLE_POS = 1;
  localparam int DH_DEVICE_SELECT_POS = 4;
  localparam int DH_LBA_MODE_POS = 6;
  localparam int HR_FLOATING_POS = 7;
  localparam int HR_WRITE_ACTIVE_POS = 6;

  // ==========================================================
  // Register file carried as one struct
  typedef struct packed {
    logic [7:0] error_and_features;
    logic [7:0] features;
    logic [7:0] sectors_to_transfer;
    logic [7:0] start_sector_or_lba_low;
    logic [7:0] cylinder_low_or_lba_mid;
    logic [7:0] cylinder_high_or_lba_high;
    logic [7:0] device_and_head_select;
    logic interrupt_disable_bit;
  } dhrp_regs_t;

  // Decoded host access
  typedef enum logic [2:0] {
    ACC_NONE,
    ACC_CMD,
    ACC_ALT_STAT,
    ACC_HEAD_READ,
    ACC_FLOAT,
    ACC_INVALID
  } dhrp_acc_t;

endpackage

// File: hw/dhrp_sync.sv
// Two-flop synchroniser for a bus of asynchronous pin levels.
// Assumes nothing reads the first stage except the second stage.
module dhrp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic soft_reset_bit,
  // Asynchronous level in, synchronised level out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg; // First stage, read only by second stage
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  // ==========================================================
  // Next-state values
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (soft_reset_bit) begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule

// File: hw/dhrp_port.sv
// Host-facing register port of a parallel disk interface.
// Assumes host pins are asynchronous and pass the synchroniser before use;
// strobe pulses are long enough (>= 3 core cycles) to be seen.

// Notes on behaviour
// - Decode selects, address, strobes into registers
// - Command block address map, eight registers
// - Addresses 3..6 hold LBA or CHS fields
// - Control block: alt status, control, head readback
// - Unmapped or double select floats bus
// - Upper lines valid only for 16-bit data
// - Reset loads 01 and 00 values
// - Alt status equals primary status
// - Alt status read keeps pending interrupt
// - Device control: soft reset, interrupt disable
// - Soft reset bit resets the device
// - Interrupt driven only enabled and selected
// - Head readback shows selected device info
// - DMA releases bus after every word
// - Head readback bit layout, inverted head
// - Status read acknowledges the interrupt
// - Reset, soft reset, command clear interrupt
// - Device select bit picks primary/secondary
module dhrp_port (
  // Clock and reset
  input wire logic core_clk,
  input wire logic soft_reset_bit,
  // Host bus pins (asynchronous)
  input wire logic command_block_select_n,
  input wire logic control_block_select_n,
  input wire logic [2:0] dev_addr,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic dma_ack_n,
  input wire logic [15:0] data_in,
  // Data bus drive
  output logic [15:0] data_out,
  output logic data_oe_low,
  output logic data_oe_high,
  // Interrupt pin (three-state)
  output logic intrq_out,
  output logic intrq_oe,
  // 16-bit indication, open drain: low while enabled
  output logic wide_oe,
  // Device-side core interface
  input wire logic device_strap,
  input wire logic [7:0] core_status,
  input wire logic core_int_pending,
  input wire logic core_write_active,
  input wire logic core_ecc_phase,
  input wire logic [15:0] core_rd_data,
  output logic [15:0] core_wr_data,
  output logic core_wr_valid,
  output logic core_rd_taken,
  output logic [7:0] core_command,
  output logic core_command_valid,
  output logic [7:0] core_features,
  output logic core_soft_reset,
  output logic core_int_clear
);

  // ==========================================================
  // Synchronised pins
  logic [6:0] ctl_s;
  logic [15:0] din_s;
  logic cs1_n, cs3_n, rd_n, wr_n, dack_n;
  logic [2:0] addr;

  dhrp_sync #(.W(7), .INIT(7'h7f)) u_sync_ctl (
    .core_clk(core_clk),
    .soft_reset_bit(soft_reset_bit),
    .async_in({command_block_select_n, control_block_select_n,
      read_strobe_n, write_strobe_n, dma_ack_n, dev_addr[1:0]}),
    .sync_out(ctl_s)
  );
  dhrp_sync #(.W(16), .INIT(16'h0000)) u_sync_data (
    .core_clk(core_clk),
    .soft_reset_bit(soft_reset_bit),
    .async_in(data_in),
    .sync_out(din_s)
  );
  logic a2_meta_reg, a2_reg; // Third address bit, own two stages

  // Third address bit synchroniser; only a2_reg is read by logic
  always_ff @(posedge core_clk) begin
    if (soft_reset_bit) begin
      a2_meta_reg <= 1'b0;
      a2_reg <= 1'b0;
    end else begin
      a2_meta_reg <= dev_addr[2];
      a2_reg <= a2_meta_reg;
    end
  end

  assign {cs1_n, cs3_n, rd_n, wr_n, dack_n} = ctl_s[6:2];
  assign addr = {a2_reg, ctl_s[1:0]};

  // ==========================================================
  // Address decode, used for the drive and the readback path
  function automatic dhrp_pkg::dhrp_acc_t decode(input logic c1n,
      input logic c3n, input logic [2:0] a);
    if (!c1n && !c3n)
      decode = dhrp_pkg::ACC_INVALID;
    else if (!c1n)
      decode = dhrp_pkg::ACC_CMD;
    else if (!c3n && a == dhrp_pkg::CTL_ALT_STAT)
      decode = dhrp_pkg::ACC_ALT_STAT;
    else if (!c3n && a == dhrp_pkg::CTL_HEAD_READ)
      decode = dhrp_pkg::ACC_HEAD_READ;
    else if (!c3n)
      decode = dhrp_pkg::ACC_FLOAT;
    else
      decode = dhrp_pkg::ACC_NONE;
  endfunction

  dhrp_pkg::dhrp_acc_t acc;
  logic dma_mode;
  assign acc = decode(cs1_n, cs3_n, addr);
  assign dma_mode = !dack_n;

  // ==========================================================
  // Strobe edge detection on the synchronised level
  logic rd_prev_reg, rd_prev_next, wr_prev_reg, wr_prev_next;
  logic rd_rise, wr_rise, rd_active;
  always_comb begin
    rd_prev_next = rd_n;
    wr_prev_next = wr_n;
  end
  assign rd_rise = rd_n && !rd_prev_reg;
  assign wr_rise = wr_n && !wr_prev_reg;
  assign rd_active = !rd_n;

  // ==========================================================
  // Register file and side effects
  dhrp_pkg::dhrp_regs_t regs_reg, regs_next;
  logic [7:0] cmd_next;
  logic cmd_valid_next, wr_valid_next, rd_taken_next;
  logic soft_reset_next, int_clear_next, dctl_soft_reset_bit_reg, dctl_soft_reset_bit_next;
  logic [15:0] wr_data_next;
  logic soft_rst;

  // Soft reset holds the registers except features and interrupt disable at reset values while the bit stays set
  assign soft_rst = dctl_soft_reset_bit_reg;

  always_comb begin
    regs_next = regs_reg;
    cmd_next = core_command;
    cmd_valid_next = 1'b0;
    wr_valid_next = 1'b0;
    rd_taken_next = 1'b0;
    int_clear_next = 1'b0;
    wr_data_next = core_wr_data;
    dctl_soft_reset_bit_next = dctl_soft_reset_bit_reg;
    if (soft_rst) begin
      // Reset values; features and interrupt disable survive so software keeps control
      regs_next.error_and_features = dhrp_pkg::RST_ERR;
      regs_next.sectors_to_transfer = dhrp_pkg::RST_SECT_CNT;
      regs_next.start_sector_or_lba_low = dhrp_pkg::RST_SECT_NUM;
      regs_next.cylinder_low_or_lba_mid = dhrp_pkg::RST_CYL_LOW;
      regs_next.cylinder_high_or_lba_high = dhrp_pkg::RST_CYL_HIGH;
      regs_next.device_and_head_select = dhrp_pkg::RST_DEV_HEAD;
      int_clear_next = 1'b1;
    end
    if (dma_mode) begin
      // DMA words go straight to the data path, registers untouched
      if (wr_rise) begin
        wr_valid_next = 1'b1;
        wr_data_next = din_s;
      end
      if (rd_rise)
        rd_taken_next = 1'b1;
    end else if (wr_rise) begin
      unique case (acc)
        dhrp_pkg::ACC_CMD: begin
          unique case (addr)
            dhrp_pkg::CMD_DATA: begin
              wr_valid_next = 1'b1;
              // ECC bytes use the low lane only
              wr_data_next = core_ecc_phase ? {8'h00, din_s[7:0]} : din_s;
            end
            dhrp_pkg::CMD_ERR_FEAT: regs_next.features = din_s[7:0];
            dhrp_pkg::CMD_SECT_CNT:
              regs_next.sectors_to_transfer = din_s[7:0];
            dhrp_pkg::CMD_SECT_NUM:
              regs_next.start_sector_or_lba_low = din_s[7:0];
            dhrp_pkg::CMD_CYL_LOW:
              regs_next.cylinder_low_or_lba_mid = din_s[7:0];
            dhrp_pkg::CMD_CYL_HIGH:
              regs_next.cylinder_high_or_lba_high = din_s[7:0];
            dhrp_pkg::CMD_DEV_HEAD:
              regs_next.device_and_head_select = din_s[7:0];
            dhrp_pkg::CMD_STAT_CMD: begin
              cmd_next = din_s[7:0];
              cmd_valid_next = 1'b1;
              int_clear_next = 1'b1;
            end
          endcase
        end
        dhrp_pkg::ACC_ALT_STAT: begin
          // Device control write: soft reset and interrupt disable
          dctl_soft_reset_bit_next = din_s[dhrp_pkg::DCTL_SOFT_RESET_POS];
          regs_next.interrupt_disable_bit =
            din_s[dhrp_pkg::DCTL_INT_DISABLE_POS];
        end
        default: ; // Head readback, float and invalid ignore writes
      endcase
    end else if (rd_rise && acc == dhrp_pkg::ACC_CMD) begin
      if (addr == dhrp_pkg::CMD_STAT_CMD)
        int_clear_next = 1'b1;
      if (addr == dhrp_pkg::CMD_DATA)
        rd_taken_next = 1'b1;
    end
  end

  // ==========================================================
  // Read data selection and bus drive
  logic selected;
  logic [7:0] head_read;
  logic [15:0] dout_next;
  logic oe_lo_next, oe_hi_next, wide_next, intrq_next, intrq_oe_next;

  // Device counts as selected when the select bit matches its strap
  assign selected = (regs_reg.device_and_head_select
    [dhrp_pkg::DH_DEVICE_SELECT_POS] == device_strap);

  always_comb begin
    head_read = 8'h00;
    head_read[dhrp_pkg::HR_WRITE_ACTIVE_POS] = !core_write_active;
    head_read[5:2] = ~regs_reg.device_and_head_select[3:0];
    // Low bit of the pair for the selected device; the other bit is one
    head_read[1] = !regs_reg.device_and_head_select[4];
    head_read[0] = regs_reg.device_and_head_select[4];
  end

  always_comb begin
    dout_next = 16'h0000;
    oe_lo_next = 1'b0;
    oe_hi_next = 1'b0;
    wide_next = 1'b0;
    if (dma_mode) begin
      // Released after each word because oe follows the strobe level
      if (rd_active) begin
        dout_next = core_rd_data;
        oe_lo_next = 1'b1;
        oe_hi_next = 1'b1;
      end
    end else if (rd_active) begin
      unique case (acc)
        dhrp_pkg::ACC_CMD: begin
          oe_lo_next = 1'b1;
          unique case (addr)
            dhrp_pkg::CMD_DATA: begin
              dout_next = core_rd_data;
              // Upper lane only for 16-bit data, never for ECC bytes
              oe_hi_next = !core_ecc_phase;
              wide_next = !core_ecc_phase;
            end
            dhrp_pkg::CMD_ERR_FEAT:
              dout_next[7:0] = regs_reg.error_and_features;
            dhrp_pkg::CMD_SECT_CNT:
              dout_next[7:0] = regs_reg.sectors_to_transfer;
            dhrp_pkg::CMD_SECT_NUM:
              dout_next[7:0] = regs_reg.start_sector_or_lba_low;
            dhrp_pkg::CMD_CYL_LOW:
              dout_next[7:0] = regs_reg.cylinder_low_or_lba_mid;
            dhrp_pkg::CMD_CYL_HIGH:
              dout_next[7:0] = regs_reg.cylinder_high_or_lba_high;
            dhrp_pkg::CMD_DEV_HEAD:
              dout_next[7:0] = regs_reg.device_and_head_select;
            dhrp_pkg::CMD_STAT_CMD: dout_next[7:0] = core_status;
          endcase
        end
        dhrp_pkg::ACC_ALT_STAT: begin
          dout_next[7:0] = core_status;
          oe_lo_next = 1'b1;
        end
        dhrp_pkg::ACC_HEAD_READ: begin
          dout_next[7:0] = head_read;
          oe_lo_next = 1'b1; // Bit 7 is driven low along with the rest of the low lane
        end
        default: ; // Float or invalid: bus stays released
      endcase
    end
    // Interrupt pin: driven only when enabled and selected
    intrq_oe_next = !regs_reg.interrupt_disable_bit && selected;
    // Alternate status reads never reach the clear path
    intrq_next = core_int_pending && !core_int_clear;
  end

  // ==========================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (soft_reset_bit) begin
      regs_reg <= '{error_and_features: dhrp_pkg::RST_ERR,
        features: 8'h00,
        sectors_to_transfer: dhrp_pkg::RST_SECT_CNT,
        start_sector_or_lba_low: dhrp_pkg::RST_SECT_NUM,
        cylinder_low_or_lba_mid: dhrp_pkg::RST_CYL_LOW,
        cylinder_high_or_lba_high: dhrp_pkg::RST_CYL_HIGH,
        device_and_head_select: dhrp_pkg::RST_DEV_HEAD,
        interrupt_disable_bit: 1'b0};
      rd_prev_reg <= 1'b1;
      wr_prev_reg <= 1'b1;
      dctl_soft_reset_bit_reg <= 1'b0;
      core_command <= 8'h00;
      core_command_valid <= 1'b0;
      core_wr_data <= 16'h0000;
      core_wr_valid <= 1'b0;
      core_rd_taken <= 1'b0;
      core_soft_reset <= 1'b0;
      core_int_clear <= 1'b1;
      data_out <= 16'h0000;
      data_oe_low <= 1'b0;
      data_oe_high <= 1'b0;
      wide_oe <= 1'b0;
      intrq_out <= 1'b0;
      intrq_oe <= 1'b0;
    end else begin
      regs_reg <= regs_next;
      rd_prev_reg <= rd_prev_next;
      wr_prev_reg <= wr_prev_next;
      dctl_soft_reset_bit_reg <= dctl_soft_reset_bit_next;
      core_command <= cmd_next;
      core_command_valid <= cmd_valid_next;
      core_wr_data <= wr_data_next;
      core_wr_valid <= wr_valid_next;
      core_rd_taken <= rd_taken_next;
      core_soft_reset <= dctl_soft_reset_bit_next;
      core_int_clear <= int_clear_next;
      data_out <= dout_next;
      data_oe_low <= oe_lo_next;
      data_oe_high <= oe_hi_next;
      wide_oe <= wide_next;
      intrq_out <= intrq_next;
      intrq_oe <= intrq_oe_next;
    end
  end

  assign core_features = regs_reg.features;

  // ==========================================================
  // Checks
  upper_lane_a: assert property (@(posedge core_clk)
    disable iff (soft_reset_bit)
    data_oe_high |-> (dma_mode || $past(rd_active)))
    else $error("Upper lane driven outside data transfer");
  float_cs_a: assert property (@(posedge core_clk)
    disable iff (soft_reset_bit)
    (!rd_active && !dma_mode) |=> !data_oe_low)
    else $error("Bus driven without read");
  alt_stat_a: assert property (@(posedge core_clk)
    disable iff (soft_reset_bit)
    (rd_active && !dma_mode && acc == dhrp_pkg::ACC_ALT_STAT)
    |=> data_out[7:0] == $past(core_status))
    else $error("Alternate status differs from status");
  alt_noclr_a: assert property (@(posedge core_clk)
    disable iff (soft_reset_bit)
    (rd_rise && !dma_mode && acc == dhrp_pkg::ACC_ALT_STAT && !soft_rst)
    |=> !core_int_clear)
    else $error("Alternate status read cleared interrupt");
  stat_ack_a: assert property (@(posedge core_clk)
    disable iff (soft_reset_bit)
    (rd_rise && !dma_mode && acc == dhrp_pkg::ACC_CMD
    && addr == dhrp_pkg::CMD_STAT_CMD) |=> core_int_clear)
    else $error("Status read did not clear interrupt");
  cmd_clr_a: assert property (@(posedge core_clk)
    disable iff (soft_reset_bit)
    core_command_valid |-> core_int_clear)
    else $error("Command write did not clear interrupt");
  intrq_gate_a: assert property (@(posedge core_clk)
    disable iff (soft_reset_bit)
    intrq_oe |-> $past(!regs_reg.interrupt_disable_bit && selected))
    else $error("Interrupt driven while gated");
  soft_reset_bit_load_a: assert property (@(posedge core_clk)
    disable iff (soft_reset_bit)
    soft_rst |=> regs_reg.sectors_to_transfer == dhrp_pkg::RST_SECT_CNT
    && regs_reg.error_and_features == dhrp_pkg::RST_ERR)
    else $error("Soft reset did not load reset values");
  dma_rel_a: assert property (@(posedge core_clk)
    disable iff (soft_reset_bit)
    (dma_mode && !rd_active) |=> !data_oe_low)
    else $error("DMA bus not released between words");

endmodule

// File: tb/dhrp_host_model.sv
// Host adapter model that drives the drive's register port pins.
// Assumes a free running core_clk; all pins change on its falling edge.
module dhrp_host_model (
  // Clock
  input wire logic core_clk,
  // Pins toward the drive
  output logic command_block_select_n,
  output logic control_block_select_n,
  output logic [2:0] dev_addr,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic dma_ack_n,
  output logic [15:0] data_in,
  // Drive side of the shared data bus
  input wire logic [15:0] data_out,
  input wire logic data_oe_low,
  input wire logic data_oe_high
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Bus resolution
  logic [15:0] host_drv; // Host value on lanes the drive leaves
  // The drive wins each lane it enables
  assign data_in = {data_oe_high ? data_out[15:8] : host_drv[15:8],
    data_oe_low ? data_out[7:0] : host_drv[7:0]};

  initial begin
    command_block_select_n = 1'b1;
    control_block_select_n = 1'b1;
    dev_addr = 3'h0;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    dma_ack_n = 1'b1;
    host_drv = 16'h5a5a;
  end

  // ==========================================================
  // Accesses
  // DMA acknowledge level, held across a whole burst
  task automatic set_dma(input logic v);
    @(negedge core_clk);
    dma_ack_n = v;
  endtask

  // One access: selects a cycle ahead, strobe low six cycles, high five;
  // about 520 ns a word keeps far below the rate that needs ready/wait
  task automatic access(input logic wr, input logic [1:0] sel_n,
    input logic [2:0] addr, input logic [15:0] wdata,
    output logic [15:0] rdata, output logic [1:0] oe_in,
    output logic oe_after);
    @(negedge core_clk);
    {command_block_select_n, control_block_select_n} = sel_n;
    dev_addr = addr;
    if (wr) begin
      host_drv = wdata;
    end
    @(negedge core_clk);
    if (wr) begin
      write_strobe_n = 1'b0;
    end else begin
      read_strobe_n = 1'b0;
    end
    repeat (5) @(negedge core_clk);
    rdata = data_out;
    oe_in = {data_oe_high, data_oe_low};
    @(negedge core_clk);
    write_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    repeat (5) @(negedge core_clk);
    oe_after = data_oe_low | data_oe_high;
    {command_block_select_n, control_block_select_n} = 2'b11;
    // Released lines must not keep showing the last value
    host_drv = ~host_drv;
  endtask
endmodule

// File: tb/dhrp_port_tb_top.sv
// Self-checking bench for the disk host register port.
// Assumes the host model in dhrp_host_model.sv drives the pins.
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  mismatches++; $display("FAIL %s expected %h seen %h", nm, e, g); end end

module dhrp_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals
  logic core_clk = 1'b0, soft_reset_bit = 1'b1;
  logic cs1_n, cs3_n, rd_n, wr_n, dack_n;
  logic [2:0] addr;
  logic [15:0] data_in, data_out, core_rd_data, core_wr_data;
  logic data_oe_low, data_oe_high, intrq_out, intrq_oe, wide_oe;
  logic device_strap = 1'b0, core_int_pending = 1'b0;
  logic core_write_active = 1'b0, core_ecc_phase = 1'b0;
  logic [7:0] core_status = 8'h50, core_command, core_features;
  logic core_wr_valid, core_rd_taken, core_command_valid;
  logic core_soft_reset, core_int_clear;
  int mismatches = 0, check_count = 0;
  int clr_cnt = 0, cmd_cnt = 0, wr_cnt = 0, rdtk_cnt = 0, wide_cnt = 0;
  logic [15:0] rd_v, last_wr, v;
  logic [1:0] oe_v;
  logic oe_a;
  logic [6:0] eh; // Expected head readback
  logic [7:0] shadow [0:7];
  int c0, c1, seed;
  localparam logic [1:0] CMD = 2'b01; // Command block selected
  localparam logic [1:0] CTL = 2'b10; // Control block selected

  always #20 core_clk = ~core_clk;
  initial core_rd_data = 16'h0000;

  // ==========================================================
  // Instances
  dhrp_host_model dhrp_host_model_i (.core_clk(core_clk),
    .command_block_select_n(cs1_n), .control_block_select_n(cs3_n),
    .dev_addr(addr), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .dma_ack_n(dack_n), .data_in(data_in), .data_out(data_out),
    .data_oe_low(data_oe_low), .data_oe_high(data_oe_high));
  dhrp_port dhrp_port_i (.core_clk(core_clk), .soft_reset_bit(soft_reset_bit),
    .command_block_select_n(cs1_n), .control_block_select_n(cs3_n),
    .dev_addr(addr), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .dma_ack_n(dack_n), .data_in(data_in), .data_out(data_out),
    .data_oe_low(data_oe_low), .data_oe_high(data_oe_high),
    .intrq_out(intrq_out), .intrq_oe(intrq_oe), .wide_oe(wide_oe),
    .device_strap(device_strap), .core_status(core_status),
    .core_int_pending(core_int_pending),
    .core_write_active(core_write_active),
    .core_ecc_phase(core_ecc_phase), .core_rd_data(core_rd_data),
    .core_wr_data(core_wr_data), .core_wr_valid(core_wr_valid),
    .core_rd_taken(core_rd_taken), .core_command(core_command),
    .core_command_valid(core_command_valid),
    .core_features(core_features), .core_soft_reset(core_soft_reset),
    .core_int_clear(core_int_clear));

  // Count the core pulses; the pulses are too short to poll from tasks
  always @(posedge core_clk) begin
    if (core_int_clear) clr_cnt++;
    if (core_command_valid) cmd_cnt++;
    if (core_rd_taken) rdtk_cnt++;
    if (wide_oe) wide_cnt++;
    if (core_wr_valid) begin
      wr_cnt++;
      last_wr = core_wr_data;
    end
  end

  // ==========================================================
  // Helpers
  task automatic wr(input logic [1:0] s, input logic [2:0] a,
    input logic [15:0] d);
    dhrp_host_model_i.access(1'b1, s, a, d, rd_v, oe_v, oe_a);
  endtask
  task automatic rd(input logic [1:0] s, input logic [2:0] a);
    dhrp_host_model_i.access(1'b0, s, a, 16'h0000, rd_v, oe_v, oe_a);
  endtask
  function automatic logic [7:0] rst_val(input int i);
    return (i < 4) ? 8'h01 : 8'h00;
  endfunction
  // Head readback: write gate low when active, inverted head, device bits
  function automatic logic [6:0] exp_head(input logic [7:0] dh,
    input logic wa);
    return {~wa, ~dh[3:0], dh[4] ? 2'b01 : 2'b10};
  endfunction
  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog: the tests need under a thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    end_sim();
  end

  // ==========================================================
  // Tests
  initial begin
    seed = $urandom(74464);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk) soft_reset_bit = 1'b0;
    for (int i = 1; i < 7; i++) begin
      rd(CMD, 3'(i));
      `CHK("reset value", rst_val(i), rd_v[7:0])
    end
    done("reset values");
    device_strap = 1'($urandom);
    for (int i = 2; i < 7; i++) begin
      shadow[i] = 8'($urandom);
      if (i == 6) shadow[i][4] = device_strap;
      wr(CMD, 3'(i), {8'h00, shadow[i]});
    end
    for (int i = 2; i < 7; i++) begin
      rd(CMD, 3'(i));
      `CHK("register", shadow[i], rd_v[7:0])
      `CHK("byte lanes", 2'b01, oe_v)
    end
    v = 16'($urandom);
    wr(CMD, 3'h1, v);
    `CHK("features", v[7:0], core_features)
    done("register map");
    core_status = 8'($urandom);
    core_int_pending = 1'b1;
    c0 = clr_cnt;
    rd(CTL, 3'h6);
    `CHK("alt status", core_status, rd_v[7:0])
    `CHK("alt clear", c0, clr_cnt)
    rd(CMD, 3'h7);
    `CHK("status", core_status, rd_v[7:0])
    `CHK("status clear", c0 + 1, clr_cnt)
    c0 = clr_cnt;
    c1 = cmd_cnt;
    v = 16'($urandom);
    wr(CMD, 3'h7, v);
    `CHK("command", v[7:0], core_command)
    `CHK("command pulse", c1 + 1, cmd_cnt)
    `CHK("command clear", c0 + 1, clr_cnt)
    done("status and command");
    for (int i = 0; i < 6; i++) begin
      rd(CTL, 3'(i));
      `CHK("float ctl", 2'b00, oe_v)
      wr(CTL, 3'(i), 16'h00ff);
    end
    rd(2'b00, 3'h2);
    `CHK("float both", 2'b00, oe_v)
    rd(2'b11, 3'h2);
    `CHK("float none", 2'b00, oe_v)
    wr(2'b00, 3'h2, 16'h0077);
    wr(CTL, 3'h7, 16'h0000);
    rd(CMD, 3'h2);
    `CHK("ignored write", shadow[2], rd_v[7:0])
    done("unmapped places");
    wr(CTL, 3'h6, 16'h000a);
    `CHK("int disabled", 1'b0, intrq_oe)
    wr(CTL, 3'h6, 16'h0008);
    `CHK("int enabled", 1'b1, intrq_oe)
    `CHK("int level", 1'b1, intrq_out)
    wr(CMD, 3'h6, {8'h00, shadow[6] ^ 8'h10});
    `CHK("int other dev", 1'b0, intrq_oe)
    done("interrupt gating");
    for (int j = 0; j < 2; j++) begin
      core_write_active = 1'($urandom);
      v = 16'($urandom);
      v[4] = 1'(j);
      wr(CMD, 3'h6, v);
      rd(CTL, 3'h7);
      eh = exp_head(v[7:0], core_write_active);
      `CHK("head readback", eh, rd_v[6:0])
      `CHK("head lanes", 1'b0, oe_v[1])
    end
    done("head readback");
    wr(CTL, 3'h6, 16'h000c);
    `CHK("soft reset", 1'b1, core_soft_reset)
    wr(CTL, 3'h6, 16'h0008);
    `CHK("soft reset end", 1'b0, core_soft_reset)
    for (int i = 1; i < 7; i++) begin
      rd(CMD, 3'(i));
      `CHK("soft reset value", rst_val(i), rd_v[7:0])
    end
    done("soft reset");
    core_rd_data = 16'($urandom);
    c0 = rdtk_cnt;
    c1 = wide_cnt;
    rd(CMD, 3'h0);
    `CHK("data read", core_rd_data, rd_v)
    `CHK("data lanes", 2'b11, oe_v)
    `CHK("read taken", c0 + 1, rdtk_cnt)
    `CHK("wide seen", 1'b1, wide_cnt > c1)
    core_ecc_phase = 1'b1;
    rd(CMD, 3'h0);
    `CHK("ecc lanes", 2'b01, oe_v)
    `CHK("ecc byte", core_rd_data[7:0], rd_v[7:0])
    core_ecc_phase = 1'b0;
    v = 16'($urandom);
    c0 = wr_cnt;
    wr(CMD, 3'h0, v);
    `CHK("data write", v, last_wr)
    `CHK("write pulse", c0 + 1, wr_cnt)
    done("data port");
    dhrp_host_model_i.set_dma(1'b0);
    for (int j = 0; j < 3; j++) begin
      core_rd_data = 16'($urandom);
      rd(2'b11, 3'h0);
      `CHK("dma word", core_rd_data, rd_v)
      `CHK("dma release", 1'b0, oe_a)
    end
    dhrp_host_model_i.set_dma(1'b1);
    done("dma burst");
    end_sim();
  end
endmodule
